// ---- core/store_write_buffer_consts.svh ----
`ifndef STORE_WRITE_BUFFER_CONSTS_SVH
`define STORE_WRITE_BUFFER_CONSTS_SVH

// Queue geometry
`define SWB_DEPTH 16
`define SWB_ADDR_W 32
`define SWB_DATA_W 32
// Disable bit position in the core configuration register
`define SWB_CFG_DISABLE_BIT 22

`endif

// ---- core/store_write_buffer_pkg.sv ----
package store_write_buffer_pkg;
    // Bus drain state
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_WAIT = 2'b10
    } bus_state_type;
endpackage

// ---- core/store_fifo.sv ----
`timescale 1ns/1ps
`include "store_write_buffer_consts.svh"

module store_fifo #(
    parameter int DEPTH = `SWB_DEPTH,
    parameter int WIDTH = 64
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_push,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_pop,
    output logic [WIDTH-1:0] o_data,
    output logic o_empty,
    output logic o_full,
    output logic [$clog2(DEPTH):0] o_count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    wire do_push = i_push && !o_full;
    wire do_pop = i_pop && !o_empty;

    assign o_empty = (count_r == '0);
    assign o_full = (count_r == (AW+1)'(DEPTH));
    assign o_count = count_r;
    assign o_data = mem_r[rd_ptr_r];

    // Storage: exactly one slot written per push
    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem_r[wr_ptr_r] <= i_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (do_push) wr_ptr_r <= wr_ptr_r + 1'b1;
            if (do_pop) rd_ptr_r <= rd_ptr_r + 1'b1;
            count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule

// ---- core/store_write_buffer.sv ----
// How it works
// RULE1 - Every uncached store and every cache store miss enters through the buffer, never directly.
// RULE2 - The buffer is a sixteen-word first-in-first-out queue drained in acceptance order.
// RULE3 - The merge latch is pushed on a non-mergeable flag, a load hit to it, or a flush or barrier.
// RULE4 - Each bus grant retires the oldest queued store onto the bus.
// RULE5 - With fifteen valid entries, a latched store and a push during a shift, one slot is used.
// RULE6 - Each accepted store appears exactly once as a bus write; the code drops a latched store that a merge overwrites.
// RULE7 - A barrier stalls the core until the buffer and latch are fully empty.
// RULE8 - Bit 22 of the core configuration register turns the buffer off entirely.
// RULE9 - With the buffer off, each write completes on the bus before the next is issued.
// RULE10 - One entry retires per grant, and core stores stall while queue and latch are full; the code still takes a store that merges into the latch.
`timescale 1ns/1ps
`include "store_write_buffer_consts.svh"

module store_write_buffer
    import store_write_buffer_pkg::*;
#(
    parameter int DEPTH = `SWB_DEPTH,
    parameter int AW = `SWB_ADDR_W,
    parameter int DW = `SWB_DATA_W
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [31:0] i_core_configuration_register,
    input wire logic i_st_valid,
    input wire logic [AW-1:0] i_st_addr,
    input wire logic [DW-1:0] i_st_data,
    input wire logic i_st_mergeable,
    input wire logic i_ld_valid,
    input wire logic [AW-1:0] i_ld_addr,
    input wire logic i_barrier,
    output logic o_st_ready,
    output logic o_barrier_stall,
    output logic o_bus_req,
    output logic [AW-1:0] o_bus_addr,
    output logic [DW-1:0] o_bus_data,
    input wire logic i_bus_grant,
    input wire logic i_bus_done,
    output logic o_empty
);
    localparam int CW = $clog2(DEPTH) + 1;

    logic latch_vld_r;
    logic [AW-1:0] latch_addr_r;
    logic [DW-1:0] latch_data_r;
    logic latch_merge_r;
    bus_state_type state_r;
    logic [AW-1:0] bus_addr_r;
    logic [DW-1:0] bus_data_r;
    logic [AW+DW-1:0] fifo_head;
    logic fifo_empty;
    logic fifo_full;
    logic [CW-1:0] fifo_count;

    // RULE8 disable bit select
    wire wb_off = i_core_configuration_register[`SWB_CFG_DISABLE_BIT];
    wire [AW-1:0] fifo_head_addr = fifo_head[AW+DW-1:DW];
    wire bus_idle = (state_r == BUS_IDLE);
    wire load_hit = i_ld_valid && latch_vld_r && (i_ld_addr == latch_addr_r);
    wire merge_hit = i_st_valid && latch_vld_r && latch_merge_r && i_st_mergeable
        && (i_st_addr == latch_addr_r);
    // RULE3 push causes
    wire flush_req = latch_vld_r && (!latch_merge_r || load_hit || i_barrier || wb_off
        || (i_st_valid && !merge_hit));
    // RULE5 push only with a free slot
    wire push = flush_req && !fifo_full;
    // RULE4 one retire per grant
    wire pop = bus_idle && i_bus_grant && !fifo_empty;
    wire latch_free = !latch_vld_r || push;
    wire all_empty = fifo_empty && !latch_vld_r && bus_idle;
    // RULE10 stall when latch cannot take it
    wire ready_buffered = merge_hit || latch_free;
    // RULE9 unbuffered store waits for last write
    assign o_st_ready = wb_off ? all_empty : ready_buffered;
    wire st_take = i_st_valid && o_st_ready;
    // RULE7 barrier waits for drain
    assign o_barrier_stall = i_barrier && !all_empty;
    assign o_empty = all_empty;
    // RULE9 one write outstanding via bus state
    assign o_bus_req = bus_idle && !fifo_empty;
    assign o_bus_addr = bus_addr_r;
    assign o_bus_data = bus_data_r;

    // RULE2 ordered queue
    store_fifo #(.DEPTH(DEPTH), .WIDTH(AW + DW)) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_push(push),
        .i_data({latch_addr_r, latch_data_r}),
        .i_pop(pop),
        .o_data(fifo_head),
        .o_empty(fifo_empty),
        .o_full(fifo_full),
        .o_count(fifo_count)
    );

    // RULE1 merge latch capture
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latch_vld_r <= 1'b0;
            latch_addr_r <= '0;
            latch_data_r <= '0;
            latch_merge_r <= 1'b0;
        end else if (st_take) begin
            latch_vld_r <= 1'b1;
            latch_addr_r <= i_st_addr;
            latch_data_r <= i_st_data;
            latch_merge_r <= i_st_mergeable && !wb_off;
        end else if (push) begin
            latch_vld_r <= 1'b0;
        end
    end

    // RULE6 bus issue, single write per entry
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= BUS_IDLE;
            bus_addr_r <= '0;
            bus_data_r <= '0;
        end else begin
            unique case (state_r)
                BUS_IDLE: begin
                    if (pop) begin
                        state_r <= BUS_WAIT;
                        bus_addr_r <= fifo_head[AW+DW-1:DW];
                        bus_data_r <= fifo_head[DW-1:0];
                    end
                end
                BUS_WAIT: begin
                    if (i_bus_done) state_r <= BUS_IDLE;
                end
            endcase
        end
    end

    // Helper: count pushes and pops for balance checking
    logic [15:0] pushes_r;
    logic [15:0] pops_r;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pushes_r <= '0;
            pops_r <= '0;
        end else begin
            pushes_r <= pushes_r + 16'(push);
            pops_r <= pops_r + 16'(pop);
        end
    end

    property p_one_slot;
        @(posedge i_clk) disable iff (!i_rst_n)
        push && !pop |=> fifo_count == $past(fifo_count) + CW'(1);
    endproperty
    a_one_slot: assert property (p_one_slot) else $error("push took more than one slot"); // RULE5

    property p_fifo_bound;
        @(posedge i_clk) disable iff (!i_rst_n)
        fifo_count <= CW'(DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("queue over depth"); // RULE2

    property p_grant_retire;
        @(posedge i_clk) disable iff (!i_rst_n)
        bus_idle && i_bus_grant && !fifo_empty |=> state_r == BUS_WAIT
            && bus_addr_r == $past(fifo_head_addr);
    endproperty
    a_grant_retire: assert property (p_grant_retire) else $error("grant did not retire head"); // RULE4

    property p_no_req_waiting;
        @(posedge i_clk) disable iff (!i_rst_n)
        state_r == BUS_WAIT |-> !o_bus_req;
    endproperty
    a_no_req_waiting: assert property (p_no_req_waiting) else $error("second write issued"); // RULE9

    property p_balance;
        @(posedge i_clk) disable iff (!i_rst_n)
        pushes_r - pops_r == 16'(fifo_count);
    endproperty
    a_balance: assert property (p_balance) else $error("store count mismatch"); // RULE6

    property p_barrier;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_barrier && !o_barrier_stall |-> pushes_r == pops_r && !latch_vld_r && state_r == BUS_IDLE;
    endproperty
    a_barrier: assert property (p_barrier) else $error("barrier released early"); // RULE7

    property p_stall_full;
        @(posedge i_clk) disable iff (!i_rst_n)
        fifo_full && latch_vld_r && !merge_hit |-> !o_st_ready;
    endproperty
    a_stall_full: assert property (p_stall_full) else $error("store taken while full"); // RULE10

    property p_flush_cause;
        @(posedge i_clk) disable iff (!i_rst_n)
        latch_vld_r && load_hit && !fifo_full |=> !latch_vld_r || $past(st_take);
    endproperty
    a_flush_cause: assert property (p_flush_cause) else $error("latch not pushed on load hit"); // RULE3

    property p_off_nomerge;
        @(posedge i_clk) disable iff (!i_rst_n)
        st_take && wb_off |=> !latch_merge_r;
    endproperty
    a_off_nomerge: assert property (p_off_nomerge) else $error("merge while disabled"); // RULE8

    property p_corner_once;
        @(posedge i_clk) disable iff (!i_rst_n)
        fifo_count == CW'(DEPTH - 1) && push && pop |=> fifo_count == CW'(DEPTH - 1);
    endproperty
    a_corner_once: assert property (p_corner_once) else $error("corner store took two slots"); // RULE5

    property p_off_wait;
        @(posedge i_clk) disable iff (!i_rst_n)
        wb_off && (latch_vld_r || state_r == BUS_WAIT || pushes_r != pops_r) |-> !o_st_ready;
    endproperty
    a_off_wait: assert property (p_off_wait) else $error("store taken before last write"); // RULE9

    property p_one_retire;
        @(posedge i_clk) disable iff (!i_rst_n)
        pop |=> !pop;
    endproperty
    a_one_retire: assert property (p_one_retire) else $error("two retires for one grant"); // RULE10

    c_full: cover property (@(posedge i_clk) fifo_full && latch_vld_r);
    c_corner: cover property (@(posedge i_clk) fifo_count == CW'(DEPTH - 1) && push && pop);
    c_barrier: cover property (@(posedge i_clk) o_barrier_stall ##1 !o_barrier_stall);
    c_merge: cover property (@(posedge i_clk) merge_hit);
endmodule

// ---- verif/bus_slave_model.sv ----
`timescale 1ns/1ps

module bus_slave_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_slow,
    input wire logic i_bus_req,
    input wire logic [31:0] i_bus_addr,
    input wire logic [31:0] i_bus_data,
    output logic o_bus_grant,
    output logic o_bus_done
);
    logic busy_r;
    int cnt_r;
    int overlap;
    logic [31:0] wa[$];
    logic [31:0] wd[$];

    // Grant one write at a time, finish it after a short or long wait
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bus_grant <= 1'b0;
            o_bus_done <= 1'b0;
            busy_r <= 1'b0;
            cnt_r <= 0;
            overlap = 0;
        end else begin
            o_bus_grant <= 1'b0;
            o_bus_done <= 1'b0;
            if (busy_r && i_bus_req && !o_bus_grant) begin
                overlap++;
            end
            if (busy_r) begin
                if (cnt_r == 0) begin
                    o_bus_done <= 1'b1;
                    busy_r <= 1'b0;
                    wa.push_back(i_bus_addr);
                    wd.push_back(i_bus_data);
                end else begin
                    cnt_r <= cnt_r - 1;
                end
            end else if (i_bus_req && !o_bus_grant) begin
                o_bus_grant <= 1'b1;
                busy_r <= 1'b1;
                cnt_r <= i_slow ? 20 : 1;
            end
        end
    end
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("FAIL %s exp %h got %h", n, e, g); end end

module tb_top;
    logic i_clk = 0, i_rst_n = 0, i_st_valid = 0, i_st_mergeable = 0, i_ld_valid = 0;
    logic i_barrier = 0, slow = 0, o_st_ready, o_barrier_stall, o_bus_req, o_empty;
    logic i_bus_grant, i_bus_done;
    logic [31:0] cfg = 0, i_st_addr = 0, i_st_data = 0, i_ld_addr = 0, o_bus_addr, o_bus_data;
    logic [31:0] ea[$];
    logic [31:0] ed[$];
    int bad_count = 0, samples_checked = 0, refused = 0, cyc = 0;

    store_write_buffer i_store_write_buffer (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_core_configuration_register(cfg), .i_st_valid(i_st_valid), .i_st_addr(i_st_addr),
        .i_st_data(i_st_data), .i_st_mergeable(i_st_mergeable), .i_ld_valid(i_ld_valid),
        .i_ld_addr(i_ld_addr), .i_barrier(i_barrier), .o_st_ready(o_st_ready),
        .o_barrier_stall(o_barrier_stall), .o_bus_req(o_bus_req), .o_bus_addr(o_bus_addr),
        .o_bus_data(o_bus_data), .i_bus_grant(i_bus_grant), .i_bus_done(i_bus_done),
        .o_empty(o_empty));
    bus_slave_model i_bus_slave_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(slow),
        .i_bus_req(o_bus_req), .i_bus_addr(o_bus_addr), .i_bus_data(o_bus_data),
        .o_bus_grant(i_bus_grant), .o_bus_done(i_bus_done));

    always #20 i_clk = ~i_clk;

    // Hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // One store, held until taken
    task automatic put(input logic [31:0] a, input logic [31:0] d, input logic m);
        int n;
        n = 0;
        @(posedge i_clk);
        i_st_valid <= 1'b1;
        i_st_addr <= a;
        i_st_data <= d;
        i_st_mergeable <= m;
        do begin
            @(negedge i_clk);
            if (o_st_ready !== 1'b1) refused++;
            n++;
        end while (o_st_ready !== 1'b1 && n < 500);
        @(posedge i_clk);
        i_st_valid <= 1'b0;
        ea.push_back(a);
        ed.push_back(d);
    endtask

    // Barrier held until stall drops
    task automatic flush();
        int n;
        n = 0;
        @(posedge i_clk);
        i_barrier <= 1'b1;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_barrier_stall !== 1'b0 && n < 2000);
        `CHK("empty_after_barrier", 1'b1, o_empty)
        @(posedge i_clk);
        i_barrier <= 1'b0;
    endtask

    // Bus writes against accepted stores, whole history
    task automatic cmp(input string t);
        `CHK("write_count", ea.size(), i_bus_slave_model.wa.size())
        for (int k = 0; k < ea.size() && k < i_bus_slave_model.wa.size(); k++) begin
            `CHK("bus_addr", ea[k], i_bus_slave_model.wa[k])
            `CHK("bus_data", ed[k], i_bus_slave_model.wd[k])
        end
        $display("test %s done", t);
    endtask

    task automatic t_order();
        for (int k = 0; k < 4; k++) put(32'h0000_0100 + 4 * k, 32'h0000_00a0 + k, 1'b0);
        flush();
        cmp("order");
    endtask

    task automatic t_full();
        slow <= 1'b1;
        refused = 0;
        for (int k = 0; k < 20; k++) put(32'h0000_0200 + 4 * k, 32'h0000_00b0 + k, 1'b0);
        `CHK("core_stalled", 1'b1, refused > 0)
        flush();
        slow <= 1'b0;
        cmp("full");
    endtask

    task automatic t_load();
        int n;
        put(32'h0000_0300, 32'h0000_00c0, 1'b1);
        // Same address mergeable store overwrites the latch
        put(32'h0000_0300, 32'h0000_00c1, 1'b1);
        void'(ea.pop_back());
        ed.delete(ed.size() - 2);
        i_ld_valid <= 1'b1;
        i_ld_addr <= 32'h0000_0300;
        n = 0;
        while (i_bus_slave_model.wa.size() != ea.size() && n < 50) begin
            @(negedge i_clk);
            n++;
        end
        `CHK("load_push", ea.size(), i_bus_slave_model.wa.size())
        @(posedge i_clk);
        i_ld_valid <= 1'b0;
        cmp("load");
    endtask

    task automatic t_off();
        cfg <= 32'h0040_0000;
        put(32'h0000_0400, 32'h0000_00d0, 1'b1);
        refused = 0;
        put(32'h0000_0400, 32'h0000_00d1, 1'b1);
        `CHK("off_store_waited", 1'b1, refused > 0)
        `CHK("off_first_done", ea.size() - 1, i_bus_slave_model.wa.size())
        flush();
        `CHK("one_outstanding", 0, i_bus_slave_model.overlap)
        cfg <= 32'h0000_0000;
        cmp("disabled");
    endtask

    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_order();
        t_full();
        t_load();
        t_off();
        tally_and_finish();
    end
endmodule
